/* File: rtl/emb_cfg.svh */
// Constants for the embedded memory block: sizes, register map, field layout
`ifndef EMB_CFG_SVH
`define EMB_CFG_SVH

// Array geometry
`define EMB_DW          16
`define EMB_AW          12
`define EMB_BITS        4096
`define EMB_ROW_AW      8
`define EMB_ROW_LG      4
`define EMB_WSEL_MAX    3'h4

// Search table geometry
`define EMB_CAM_WORDS   32
`define EMB_CAM_AW      5
`define EMB_MATCH_W     16
`define EMB_ENC_W       4

// Register offsets
`define EMB_REG_AW      4
`define EMB_REG_CTRL    4'h0
`define EMB_REG_CFGADR  4'h4
`define EMB_REG_CFGDAT  4'h8
`define EMB_REG_STATUS  4'hC

// Control register fields
`define EMB_CTRL_MODE   1:0
`define EMB_CTRL_WSEL   6:4
`define EMB_CTRL_BYP    13:8
`define EMB_CTRL_RST    32'h0000_0000
`define EMB_CTRL_MASK   32'h0000_3F73

// Bypass bit positions inside the bypass field
`define EMB_BYP_DIN     0
`define EMB_BYP_DOUT    1
`define EMB_BYP_RADDR   2
`define EMB_BYP_WADDR   3
`define EMB_BYP_WE      4
`define EMB_BYP_RE      5

// Status register fields
`define EMB_STAT_WBUSY  0
`define EMB_STAT_SBUSY  1
`define EMB_STAT_ENC    6:2
`define EMB_STAT_ENCV   7

`endif

/* File: rtl/emb_pkg.sv */
// Types shared by the embedded memory block modules
package emb_pkg;

  // Operating mode, Gray ordered RAM -> ROM -> fast search -> multi search
  typedef enum logic [1:0] {
    EMB_RAM  = 2'b00,
    EMB_ROM  = 2'b01,
    EMB_FCAM = 2'b11,
    EMB_CAM  = 2'b10
  } emb_mode_e;

  // Search table write sequence
  typedef enum logic [1:0] {
    EMB_W_IDLE = 2'b00,
    EMB_W_ONE  = 2'b01,
    EMB_W_TWO  = 2'b11
  } emb_wstate_e;

endpackage : emb_pkg

/* File: rtl/emb_cam_if.sv */
// Signals between the memory block top and its search table
`timescale 1ns/1ns
`include "emb_cfg.svh"
interface emb_cam_if;
  logic                     wr;
  logic [`EMB_CAM_AW-1:0]   waddr;
  logic [`EMB_DW-1:0]       wdata;
  logic [`EMB_DW-1:0]       dcare;
  logic                     cfg_wr;
  logic [`EMB_CAM_AW-1:0]   cfg_addr;
  logic [`EMB_DW-1:0]       cfg_data;
  logic                     fast;
  logic                     search;
  logic [`EMB_DW-1:0]       key;
  logic [`EMB_MATCH_W-1:0]  match;
  logic                     half;
  logic                     valid;
  logic                     wbusy;
  logic                     commit;

  modport ctl (output wr, waddr, wdata, dcare, cfg_wr, cfg_addr, cfg_data, fast, search, key,
               input match, half, valid, wbusy, commit);
  modport cam (input wr, waddr, wdata, dcare, cfg_wr, cfg_addr, cfg_data, fast, search, key,
               output match, half, valid, wbusy, commit);
endinterface : emb_cam_if

/* File: rtl/emb_cam_match.sv */
// Search table: masked word store, timed write sequence, 16-lane compare
`timescale 1ns/1ns
`include "emb_cfg.svh"
module emb_cam_match
  import emb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Table side
  emb_cam_if.cam   cam
);

  logic [`EMB_DW-1:0]        val_mem  [`EMB_CAM_WORDS];
  logic [`EMB_DW-1:0]        care_mem [`EMB_CAM_WORDS];
  logic [`EMB_CAM_WORDS-1:0] used_reg;
  emb_wstate_e               wst_reg, wst_next;
  logic                      phase_reg;
  logic [`EMB_DW-1:0]        key_reg;
  logic [`EMB_CAM_AW-1:0]    wslot;
  logic [`EMB_DW-1:0]        cur_key;
  logic                      has_dc;

  // Fast mode owns only the lower sixteen words
  assign wslot   = cam.fast ? {1'b0, cam.waddr[`EMB_CAM_AW-2:0]} : cam.waddr;
  assign has_dc  = |cam.dcare;
  assign cur_key = phase_reg ? key_reg : cam.key;

  // Write sequence: two held cycles, a third when don't-care bits are present
  always_comb begin
    wst_next   = EMB_W_IDLE;
    cam.commit = 1'b0;
    case (wst_reg)
      EMB_W_IDLE: wst_next = cam.wr ? EMB_W_ONE : EMB_W_IDLE;
      EMB_W_ONE: begin
        if (cam.wr && has_dc) begin
          wst_next = EMB_W_TWO;
        end else begin
          cam.commit = cam.wr;
        end
      end
      EMB_W_TWO: cam.commit = cam.wr;
      default:   wst_next = EMB_W_IDLE;
    endcase
  end

  // Sequence state, search phase and held key
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wst_reg   <= EMB_W_IDLE;
      phase_reg <= 1'b0;
      key_reg   <= '0;
    end else begin
      wst_reg   <= wst_next;
      phase_reg <= !cam.fast && !phase_reg && cam.search;
      key_reg   <= phase_reg ? key_reg : cam.key;
    end
  end

  // Word store; configuration preload stores an exact-match word
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      used_reg <= '0;
    end else if (cam.cfg_wr) begin
      val_mem[cam.cfg_addr]  <= cam.cfg_data;
      care_mem[cam.cfg_addr] <= '1;
      used_reg[cam.cfg_addr] <= 1'b1;
    end else if (cam.commit) begin
      val_mem[wslot]  <= cam.wdata;
      care_mem[wslot] <= ~cam.dcare;
      used_reg[wslot] <= 1'b1;
    end
  end

  // Sixteen lanes compared per cycle; the upper half waits for the second phase
  always_comb begin
    for (int i = 0; i < `EMB_MATCH_W; i++) begin
      cam.match[i] = used_reg[{phase_reg, 4'(i)}] &&
                     (((cur_key ^ val_mem[{phase_reg, 4'(i)}]) & care_mem[{phase_reg, 4'(i)}]) == '0);
    end
  end

  assign cam.half  = phase_reg;
  assign cam.valid = cam.search || phase_reg;
  assign cam.wbusy = (wst_reg != EMB_W_IDLE);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_write_two_cycles: assert property (
    (wst_reg == EMB_W_IDLE && cam.wr && !has_dc) ##1 (cam.wr && !has_dc) |-> cam.commit)
    else $error("search word not stored after two held cycles");
  chk_write_dc_three: assert property (
    (wst_reg == EMB_W_IDLE && cam.wr && has_dc) ##1 (cam.wr && has_dc) |-> !cam.commit ##1 (!cam.wr || cam.commit))
    else $error("don't-care write did not take exactly three cycles");
  cov_write_dc: cover property (wst_reg == EMB_W_TWO && cam.commit);

endmodule : emb_cam_match

/* File: rtl/emb_memory_block.sv */
// Embedded memory block: dual-port RAM, ROM and search table with register port
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "emb_cfg.svh"
module emb_memory_block
  import emb_pkg::*;
(
  // Clock and reset
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RSTN_I,
  // Register port
  input  wire logic [`EMB_REG_AW-1:0]  REG_ADDR_I,
  input  wire logic [31:0]             REG_WDATA_I,
  input  wire logic                    REG_WR_I,
  input  wire logic                    REG_RD_I,
  output wire logic [31:0]             REG_RDATA_O,
  // Port A
  input  wire logic [`EMB_DW-1:0]      DIN_A_I,
  input  wire logic [`EMB_AW-1:0]      WADDR_A_I,
  input  wire logic [`EMB_AW-1:0]      RADDR_A_I,
  input  wire logic                    WRITE_STROBE_IN_A_I,
  input  wire logic                    READ_STROBE_A_I,
  input  wire logic                    WCE_A_I,
  input  wire logic                    RCE_A_I,
  input  wire logic                    CLR_A_I,
  output wire logic [`EMB_DW-1:0]      DOUT_A_O,
  // Port B
  input  wire logic [`EMB_DW-1:0]      DIN_B_I,
  input  wire logic [`EMB_AW-1:0]      WADDR_B_I,
  input  wire logic [`EMB_AW-1:0]      RADDR_B_I,
  input  wire logic                    WRITE_STROBE_IN_B_I,
  input  wire logic                    READ_STROBE_B_I,
  input  wire logic                    WCE_B_I,
  input  wire logic                    RCE_B_I,
  input  wire logic                    CLR_B_I,
  output wire logic [`EMB_DW-1:0]      DOUT_B_O,
  // Search
  input  wire logic [`EMB_DW-1:0]      CAM_DONTCARE_I,
  input  wire logic                    SEARCH_I,
  input  wire logic [`EMB_DW-1:0]      SEARCH_KEY_I,
  output wire logic [`EMB_MATCH_W-1:0] MATCH_O,
  output wire logic                    MATCH_HALF_O,
  output wire logic                    MATCH_VALID_O,
  output wire logic [`EMB_CAM_AW-1:0]  ENC_ADDR_O,
  output wire logic                    ENC_VALID_O
);

  // Width code 0..4 selects 16..1 bits per word; returns log2 of the width
  function automatic logic [2:0] width_log(input logic [2:0] sel);
    width_log = (sel > `EMB_WSEL_MAX) ? 3'h0 : 3'(`EMB_WSEL_MAX - sel);
  endfunction : width_log

  // First bit of a word; address bits beyond the configured depth fall off
  function automatic logic [`EMB_AW-1:0] bit_base(input logic [`EMB_AW-1:0] addr, input logic [2:0] lg);
    bit_base = `EMB_AW'(addr << lg);
  endfunction : bit_base

  // Lowest set lane, with a found flag on top
  function automatic logic [`EMB_ENC_W:0] prio_enc(input logic [`EMB_MATCH_W-1:0] m);
    prio_enc = '0;
    for (int i = `EMB_MATCH_W - 1; i >= 0; i--) begin
      if (m[i]) begin
        prio_enc = {1'b1, `EMB_ENC_W'(i)};
      end
    end
  endfunction : prio_enc

  // Software state
  logic [31:0]              ctrl_reg;
  logic [`EMB_AW-1:0]       cfg_addr_reg;
  logic [31:0]              rdata_reg;

  // Per-port pins gathered into arrays
  logic [`EMB_DW-1:0]       din_pin   [2];
  logic [`EMB_AW-1:0]       waddr_pin [2];
  logic [`EMB_AW-1:0]       raddr_pin [2];
  logic [1:0]               we_pin, re_pin, wce_pin, rce_pin, clr_pin;

  // Input register stage
  logic [`EMB_DW-1:0]       din_reg   [2];
  logic [`EMB_AW-1:0]       waddr_reg [2];
  logic [`EMB_AW-1:0]       raddr_reg [2];
  logic [1:0]               we_reg, re_reg;

  // Effective values after bypass selection
  logic [`EMB_DW-1:0]       din_eff   [2];
  logic [`EMB_AW-1:0]       wbase     [2];
  logic [`EMB_AW-1:0]       rbase     [2];
  logic [1:0]               we_eff, re_eff, ram_we, out_ld;
  logic [`EMB_DW-1:0]       rd_word   [2];
  logic [`EMB_DW-1:0]       cfg_row;
  logic                     mem_bits  [`EMB_BITS];

  // Search output stage
  logic [`EMB_MATCH_W-1:0]  match_reg;
  logic                     half_reg, mvalid_reg, encv_reg;
  logic [`EMB_CAM_AW-1:0]   enc_reg;
  logic [`EMB_ENC_W:0]      enc_raw;
  logic [`EMB_DW-1:0]       dc_reg;
  emb_cam_if                cam_if_i ();

  emb_mode_e                mode;
  logic [2:0]               lg_w;
  logic [5:0]               byp;
  logic [`EMB_DW-1:0]       wmask;
  logic                     cam_mode, wr_ctrl, wr_cfgadr, wr_cfgdat;

  // Decode of software controls
  assign mode      = emb_mode_e'(ctrl_reg[`EMB_CTRL_MODE]);
  assign lg_w      = width_log(ctrl_reg[`EMB_CTRL_WSEL]);
  assign byp       = ctrl_reg[`EMB_CTRL_BYP];
  assign wmask     = `EMB_DW'((`EMB_DW'(1) << (1 << lg_w)) - `EMB_DW'(1)) | (lg_w == 3'h4 ? '1 : '0);
  assign cam_mode  = (mode == EMB_CAM) || (mode == EMB_FCAM);
  assign wr_ctrl   = REG_WR_I && (REG_ADDR_I == `EMB_REG_CTRL);
  assign wr_cfgadr = REG_WR_I && (REG_ADDR_I == `EMB_REG_CFGADR);
  assign wr_cfgdat = REG_WR_I && (REG_ADDR_I == `EMB_REG_CFGDAT);

  // Port pins into arrays so both ports share one description
  assign din_pin   = '{DIN_A_I, DIN_B_I};
  assign waddr_pin = '{WADDR_A_I, WADDR_B_I};
  assign raddr_pin = '{RADDR_A_I, RADDR_B_I};
  assign we_pin    = {WRITE_STROBE_IN_B_I, WRITE_STROBE_IN_A_I};
  assign re_pin    = {READ_STROBE_B_I, READ_STROBE_A_I};
  assign wce_pin   = {WCE_B_I, WCE_A_I};
  assign rce_pin   = {RCE_B_I, RCE_A_I};
  assign clr_pin   = {CLR_B_I, CLR_A_I};

  // Register port: control, configuration address and read data one cycle later
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      ctrl_reg     <= `EMB_CTRL_RST;
      cfg_addr_reg <= '0;
      rdata_reg    <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= REG_WDATA_I & `EMB_CTRL_MASK;
      if (wr_cfgadr) cfg_addr_reg <= REG_WDATA_I[`EMB_AW-1:0];
      rdata_reg <= '0;
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          `EMB_REG_CTRL:   rdata_reg <= ctrl_reg;
          `EMB_REG_CFGADR: rdata_reg <= 32'(cfg_addr_reg);
          `EMB_REG_CFGDAT: rdata_reg <= 32'(cfg_row);
          `EMB_REG_STATUS: rdata_reg <= 32'({encv_reg, enc_reg, half_reg, cam_if_i.wbusy});
          default:         rdata_reg <= '0;
        endcase
      end
    end
  end

  // Input registers of both ports on the one input clock, each under its own write enable
  always_ff @(posedge REF_CLK_I) begin
    for (int p = 0; p < 2; p++) begin
      if (!RSTN_I) begin
        din_reg[p]   <= '0;
        waddr_reg[p] <= '0;
        raddr_reg[p] <= '0;
        we_reg[p]    <= 1'b0;
        re_reg[p]    <= 1'b0;
      end else if (wce_pin[p]) begin
        din_reg[p]   <= din_pin[p];
        waddr_reg[p] <= waddr_pin[p];
        raddr_reg[p] <= raddr_pin[p];
        we_reg[p]    <= we_pin[p];
        re_reg[p]    <= re_pin[p];
      end
    end
  end

  // Bypass selection per register; a bypassed input stage passes the pin straight through, a bypassed output ignores its read enable
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      din_eff[p] = byp[`EMB_BYP_DIN] ? din_pin[p] : din_reg[p];
      wbase[p]   = bit_base(byp[`EMB_BYP_WADDR] ? waddr_pin[p] : waddr_reg[p], lg_w);
      rbase[p]   = bit_base(byp[`EMB_BYP_RADDR] ? raddr_pin[p] : raddr_reg[p], lg_w);
      we_eff[p]  = byp[`EMB_BYP_WE] ? we_pin[p] : we_reg[p];
      re_eff[p]  = byp[`EMB_BYP_RE] ? re_pin[p] : re_reg[p];
      ram_we[p]  = we_eff[p] && (mode == EMB_RAM);
      out_ld[p]  = re_eff[p] && !cam_mode && (rce_pin[p] || byp[`EMB_BYP_DOUT]);
    end
  end

  // Unless the write strobe is bypassed, a run-time write lands at the edge after its strobe has been registered
  // Array: port A then port B then configuration, so configuration wins a same-bit collision and B wins over A
  always_ff @(posedge REF_CLK_I) begin
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < `EMB_DW; i++) begin
        if (ram_we[p] && wmask[i]) mem_bits[wbase[p] + `EMB_AW'(i)] <= din_eff[p][i];
      end
    end
    for (int i = 0; i < `EMB_DW; i++) begin
      if (wr_cfgdat && !cam_mode) begin
        mem_bits[{cfg_addr_reg[`EMB_ROW_AW-1:0], `EMB_ROW_LG'(i)}] <= REG_WDATA_I[i];
      end
    end
  end

  // Read words; bits above the configured width read as zero
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < `EMB_DW; i++) begin
        rd_word[p][i] = wmask[i] && mem_bits[rbase[p] + `EMB_AW'(i)];
      end
    end
    for (int i = 0; i < `EMB_DW; i++) begin
      cfg_row[i] = mem_bits[{cfg_addr_reg[`EMB_ROW_AW-1:0], `EMB_ROW_LG'(i)}];
    end
  end

  // Output registers: clear acts without the clock, so the output drops at once
  for (genvar p = 0; p < 2; p++) begin : g_out
    logic [`EMB_DW-1:0] q_reg;
    always_ff @(posedge REF_CLK_I or posedge clr_pin[p]) begin
      if (clr_pin[p]) begin
        q_reg <= '0;
      end else if (!RSTN_I) begin
        q_reg <= '0;
      end else if (out_ld[p]) begin
        q_reg <= rd_word[p];
      end
    end
  end

  // Don't-care mask is registered beside port A data so it lines up with the registered strobe
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      dc_reg <= '0;
    end else if (wce_pin[0]) begin
      dc_reg <= CAM_DONTCARE_I;
    end
  end

  // Search table; run-time writes come through port A in search modes
  // The slot is the low bits of the word address, never the width-scaled bit base
  assign cam_if_i.wr       = we_eff[0] && cam_mode;
  assign cam_if_i.waddr    = byp[`EMB_BYP_WADDR] ? WADDR_A_I[`EMB_CAM_AW-1:0] : waddr_reg[0][`EMB_CAM_AW-1:0];
  assign cam_if_i.wdata    = din_eff[0];
  assign cam_if_i.dcare    = byp[`EMB_BYP_DIN] ? CAM_DONTCARE_I : dc_reg;
  assign cam_if_i.cfg_wr   = wr_cfgdat && cam_mode;
  assign cam_if_i.cfg_addr = cfg_addr_reg[`EMB_CAM_AW-1:0];
  assign cam_if_i.cfg_data = REG_WDATA_I[`EMB_DW-1:0];
  assign cam_if_i.fast     = (mode == EMB_FCAM);
  assign cam_if_i.search   = SEARCH_I && cam_mode && !cam_if_i.half;
  assign cam_if_i.key      = SEARCH_KEY_I;

  emb_cam_match u_cam (
    .clk_i  (REF_CLK_I),
    .rstn_i (RSTN_I),
    .cam    (cam_if_i.cam)
  );

  // Trailing priority encoder over the lanes of the current half
  assign enc_raw = prio_enc(cam_if_i.match);

  // Registered search results; fast mode never raises the upper half
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      match_reg  <= '0;
      half_reg   <= 1'b0;
      mvalid_reg <= 1'b0;
      enc_reg    <= '0;
      encv_reg   <= 1'b0;
    end else begin
      match_reg  <= cam_if_i.valid ? cam_if_i.match : '0;
      half_reg   <= cam_if_i.half;
      mvalid_reg <= cam_if_i.valid;
      enc_reg    <= {cam_if_i.half, enc_raw[`EMB_ENC_W-1:0]};
      encv_reg   <= cam_if_i.valid && enc_raw[`EMB_ENC_W];
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA_O   = rdata_reg;
  assign DOUT_A_O      = g_out[0].q_reg;
  assign DOUT_B_O      = g_out[1].q_reg;
  assign MATCH_O       = match_reg;
  assign MATCH_HALF_O  = half_reg;
  assign MATCH_VALID_O = mvalid_reg;
  assign ENC_ADDR_O    = enc_reg;
  assign ENC_VALID_O   = encv_reg;

  // Helper for the encoder check: lanes below the reported one
  logic [`EMB_MATCH_W-1:0] below_enc;
  assign below_enc = `EMB_MATCH_W'((`EMB_MATCH_W'(1) << ENC_ADDR_O[`EMB_ENC_W-1:0]) - `EMB_MATCH_W'(1));

  // Checks sample on the block clock and rest while reset is held
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  chk_clear_forces_zero: assert property (CLR_A_I |-> DOUT_A_O == '0)
    else $error("port A output not zero while clear is high");

  chk_out_enable_hold: assert property (
    (!RCE_B_I && !byp[`EMB_BYP_DOUT] && !CLR_B_I) |=> ($stable(DOUT_B_O) || CLR_B_I))
    else $error("port B output changed without its read enable");

  chk_in_enable_hold: assert property (!WCE_A_I |=> $stable(din_reg[0]) && $stable(we_reg[0]))
    else $error("port A input register loaded without its write enable");

  chk_rom_no_write: assert property (mode == EMB_ROM |-> ram_we == 2'b00)
    else $error("run-time write reached the array in ROM mode");

  chk_bypass_we: assert property (
    (byp[`EMB_BYP_WE] && mode == EMB_RAM) |-> ram_we[1] == WRITE_STROBE_IN_B_I)
    else $error("bypassed write strobe did not act directly");

  chk_fast_one_cycle: assert property ((mode == EMB_FCAM && SEARCH_I) |=> MATCH_VALID_O && !MATCH_HALF_O)
    else $error("fast search result not valid one cycle later");

  chk_multi_two_halves: assert property (
    (mode == EMB_CAM && SEARCH_I && !cam_if_i.half) ##1 (mode == EMB_CAM)
      |-> (MATCH_VALID_O && !MATCH_HALF_O) ##1 (MATCH_VALID_O && MATCH_HALF_O))
    else $error("multi-match search did not cover both halves in two cycles");

  chk_fast_sixteen: assert property ((mode == EMB_FCAM)[*2] |-> !MATCH_HALF_O)
    else $error("fast mode reported an upper half");

  chk_enc_lowest: assert property (
    ENC_VALID_O |-> MATCH_O[ENC_ADDR_O[`EMB_ENC_W-1:0]] && ((MATCH_O & below_enc) == '0))
    else $error("encoded address is not the lowest match");

  chk_width_zero: assert property ((out_ld[0] && !CLR_A_I) |=> ((DOUT_A_O & ~$past(wmask)) == '0 || CLR_A_I))
    else $error("bits above the word width not zero");

  // Main scenarios reached
  cov_fast_hit: cover property (mode == EMB_FCAM && SEARCH_I ##1 ENC_VALID_O);
  cov_upper_hit: cover property (MATCH_HALF_O && ENC_VALID_O);
  cov_port_read: cover property (out_ld[0] ##1 DOUT_A_O != '0);
  cov_clear: cover property (CLR_B_I ##1 !CLR_B_I);

endmodule : emb_memory_block

/* File: tb/emb_fabric_model.sv */
// Fabric-side model that drives both memory ports
`timescale 1ns/1ns
`include "emb_cfg.svh"
module emb_fabric_model (
  // Clock
  input  wire logic                   clk_i,
  // Port pins, index 0 is port A
  output logic [1:0][`EMB_DW-1:0] din_o,
  output logic [1:0][`EMB_AW-1:0] waddr_o,
  output logic [1:0][`EMB_AW-1:0] raddr_o,
  output logic [1:0]              wr_stb_o,
  output logic [1:0]              rd_stb_o,
  output logic [1:0]              wce_o,
  output logic [1:0]              rce_o,
  output logic [1:0]              clr_o,
  output logic [`EMB_DW-1:0]      dc_o
);
  // Idle state; both enables stay on so every input register loads each edge
  initial begin
    {din_o, waddr_o, raddr_o, wr_stb_o, rd_stb_o, clr_o, dc_o} = '0;
    wce_o = 2'h3;
    rce_o = 2'h3;
  end

  // Write held n cycles; a masked search word needs one cycle more
  task automatic put(input int p, input logic [11:0] a, input logic [15:0] d, input logic [15:0] m, input int n);
    @(posedge clk_i);
    din_o[p] <= d;
    waddr_o[p] <= a;
    if (p == 0) dc_o <= m;
    wr_stb_o[p] <= 1'h1;
    repeat (n) @(posedge clk_i);
    wr_stb_o[p] <= 1'h0;
    din_o[p] <= ~d; // Released lines must not keep the last value
    if (p == 0) dc_o <= ~m;
  endtask : put

  // One-cycle read request
  task automatic get(input int p, input logic [11:0] a);
    @(posedge clk_i);
    raddr_o[p] <= a;
    rd_stb_o[p] <= 1'h1;
    @(posedge clk_i);
    rd_stb_o[p] <= 1'h0;
    raddr_o[p] <= ~a;
  endtask : get
endmodule : emb_fabric_model

/* File: tb/emb_memory_block_test.sv */
// Self-checking bench for the embedded memory block
`timescale 1ns/1ns
`include "emb_cfg.svh"
module emb_memory_block_test
  import emb_pkg::*;
;
  logic                    clk;
  logic                    rstn;
  logic [`EMB_REG_AW-1:0]  reg_addr;
  logic [31:0]             reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic                    search;
  logic [`EMB_DW-1:0]      key;
  wire  [31:0]             rdata;
  wire  [1:0][`EMB_DW-1:0] dout, din;
  wire  [1:0][`EMB_AW-1:0] wa, ra;
  wire  [1:0]              ws, rs, wce, rce, clr;
  wire  [`EMB_DW-1:0]      dc;
  wire  [`EMB_MATCH_W-1:0] match;
  wire                     half, mvalid, evalid;
  wire  [`EMB_CAM_AW-1:0]  eaddr;
  logic [33:0]             exp_q[$];
  int                      miscompares;
  int                      compares;
  int                      cycles;
  event                    look;
  // Observed outputs: 0 port A, 1 port B, 2 register read, 3 search result
  wire  [3:0][31:0]        outs = {{9'h0, evalid, evalid ? eaddr : 5'h0, half, match}, rdata,
                                   16'h0, dout[1], 16'h0, dout[0]};

  emb_memory_block emb_memory_block_inst (
    .REF_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
    .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(rdata),
    .DIN_A_I(din[0]), .WADDR_A_I(wa[0]), .RADDR_A_I(ra[0]), .WRITE_STROBE_IN_A_I(ws[0]),
    .READ_STROBE_A_I(rs[0]), .WCE_A_I(wce[0]), .RCE_A_I(rce[0]), .CLR_A_I(clr[0]), .DOUT_A_O(dout[0]),
    .DIN_B_I(din[1]), .WADDR_B_I(wa[1]), .RADDR_B_I(ra[1]), .WRITE_STROBE_IN_B_I(ws[1]),
    .READ_STROBE_B_I(rs[1]), .WCE_B_I(wce[1]), .RCE_B_I(rce[1]), .CLR_B_I(clr[1]), .DOUT_B_O(dout[1]),
    .CAM_DONTCARE_I(dc), .SEARCH_I(search), .SEARCH_KEY_I(key), .MATCH_O(match),
    .MATCH_HALF_O(half), .MATCH_VALID_O(mvalid), .ENC_ADDR_O(eaddr), .ENC_VALID_O(evalid));

  emb_fabric_model emb_fabric_model_inst (
    .clk_i(clk), .din_o(din), .waddr_o(wa), .raddr_o(ra), .wr_stb_o(ws), .rd_stb_o(rs),
    .wce_o(wce), .rce_o(rce), .clr_o(clr), .dc_o(dc));

  // Clock, 50 ns period
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && compares > 0 && exp_q.size() == 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Oldest note against what is seen; an empty queue can never match
  task automatic check(input logic [31:0] got);
    logic [33:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
    compares++;
    if (got !== e[31:0]) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, e[31:0]);
    end
  endtask : check

  // Observers: announced samples, and every search result cycle
  always @(look) check(outs[exp_q[0][33:32]]);
  always @(negedge clk) if (mvalid === 1'h1) check(outs[3]);

  task automatic note(input logic [1:0] s, input logic [31:0] v);
    exp_q.push_back({s, v});
  endtask : note

  task automatic look_at(input logic [1:0] s, input logic [31:0] v);
    note(s, v);
    -> look;
  endtask : look_at

  function automatic logic [31:0] ctl(input emb_mode_e m, input logic [2:0] w, input logic [5:0] b);
    return {18'h0, b, 1'h0, w, 2'h0, m};
  endfunction : ctl

  // Search result word: {valid, {half, lowest lane}, half, lanes}
  function automatic logic [31:0] res(input logic h, input logic [3:0] lane, input logic hit);
    return {9'h0, hit, hit ? {h, lane} : 5'h0, h, hit ? 16'h1 << lane : 16'h0};
  endfunction : res

  task automatic reg_wr_op(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : reg_wr_op

  task automatic reg_rd_op(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    look_at(2'h2, v);
  endtask : reg_rd_op

  // Port read; with address and strobe registers bypassed data is one edge earlier
  task automatic rd_port(input int p, input logic [11:0] a, input logic [31:0] v, input bit byp);
    emb_fabric_model_inst.get(p, a);
    if (!byp) @(posedge clk);
    @(negedge clk);
    look_at(2'(p), v);
  endtask : rd_port

  task automatic find(input logic [15:0] k);
    @(posedge clk);
    key <= k;
    search <= 1'h1;
    @(posedge clk);
    search <= 1'h0;
    key <= ~k;
    repeat (4) @(posedge clk);
  endtask : find

  initial begin
    logic [11:0] a;
    logic [15:0] d;
    logic [15:0] e;
    {rstn, reg_addr, reg_wdata, reg_wr, reg_rd, search, key} = '0;
    void'($urandom(32'h48EC));
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    // Control register reset value, writable bits, unmapped offset
    reg_rd_op(`EMB_REG_CTRL, 32'h0);
    reg_wr_op(`EMB_REG_CTRL, 32'hFFFF_FFFF);
    reg_wr_op(4'h2, 32'h0000_0001);
    reg_rd_op(`EMB_REG_CTRL, `EMB_CTRL_MASK);
    reg_rd_op(4'h2, 32'h0);
    // Multi-match: plain word in upper half, masked word in lower half
    reg_wr_op(`EMB_REG_CTRL, ctl(EMB_CAM, 3'h0, 6'h0));
    emb_fabric_model_inst.put(0, 12'h014, 16'hA5C3, 16'h0, 2);
    emb_fabric_model_inst.put(0, 12'h003, 16'h3C70, 16'h000F, 3);
    repeat (2) @(posedge clk);
    note(2'h3, res(1'h0, 4'h0, 1'h0));
    note(2'h3, res(1'h1, 4'h4, 1'h1));
    find(16'hA5C3);
    note(2'h3, res(1'h0, 4'h3, 1'h1));
    note(2'h3, res(1'h1, 4'h0, 1'h0));
    find(16'h3C75);
    // Fast match: one result cycle only, a second would find the queue empty
    reg_wr_op(`EMB_REG_CTRL, ctl(EMB_FCAM, 3'h0, 6'h0));
    emb_fabric_model_inst.put(0, 12'h007, 16'h5A19, 16'h0, 2);
    repeat (2) @(posedge clk);
    note(2'h3, res(1'h0, 4'h7, 1'h1));
    find(16'h5A19);
    // Both ports write at once, then read each other's word
    reg_wr_op(`EMB_REG_CTRL, ctl(EMB_RAM, 3'h0, 6'h0));
    a = 12'($urandom_range(255));
    d = 16'($urandom());
    e = 16'($urandom());
    fork
      emb_fabric_model_inst.put(0, a, d, 16'h0, 1);
      emb_fabric_model_inst.put(1, a ^ 12'h080, e, 16'h0, 1);
    join
    rd_port(1, a, {16'h0, d}, 1'b0);
    rd_port(0, a ^ 12'h080, {16'h0, e}, 1'b0);
    // Output enables low keep the old words
    @(posedge clk);
    emb_fabric_model_inst.rce_o <= 2'h0;
    rd_port(0, a, {16'h0, e}, 1'b0);
    @(posedge clk);
    emb_fabric_model_inst.rce_o <= 2'h3;
    emb_fabric_model_inst.wce_o <= 2'h2;
    emb_fabric_model_inst.clr_o[0] <= 1'h1;
    #1 look_at(2'h0, 32'h0);
    #1 look_at(2'h1, {16'h0, d});
    @(posedge clk);
    emb_fabric_model_inst.clr_o[0] <= 1'h0;
    emb_fabric_model_inst.wce_o <= 2'h3;
    // Read address, write strobe and read strobe registers bypassed
    reg_wr_op(`EMB_REG_CTRL, ctl(EMB_RAM, 3'h0, 6'h34));
    rd_port(0, a, {16'h0, d}, 1'b1);
    // Deepest shape, one bit wide
    reg_wr_op(`EMB_REG_CTRL, ctl(EMB_RAM, 3'h4, 6'h0));
    emb_fabric_model_inst.put(1, 12'hFFF, 16'hFFFF, 16'h0, 1);
    rd_port(1, 12'hFFF, 32'h1, 1'b0);
    // Lookup table: preloaded row survives a port write
    reg_wr_op(`EMB_REG_CFGADR, 32'h0000_0042);
    reg_wr_op(`EMB_REG_CFGDAT, 32'h0000_9D2E);
    reg_wr_op(`EMB_REG_CTRL, ctl(EMB_ROM, 3'h0, 6'h0));
    emb_fabric_model_inst.put(0, 12'h042, 16'h1111, 16'h0, 1);
    rd_port(0, 12'h042, 32'h9D2E, 1'b0);
    reg_rd_op(`EMB_REG_CFGDAT, 32'h0000_9D2E);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : emb_memory_block_test
